// ---- core/sector_map_regs.vh ----
/*
 Register offsets, field positions, reset values and descriptor bytes
 for the sector map detection block. Assumes byte-wide registers on a
 plain strobe port with an 8-bit address.
*/
`ifndef SECTOR_MAP_REGS_VH
`define SECTOR_MAP_REGS_VH

// Read-any-register addresses of the nonvolatile configuration bytes
`define OFS_CFG_ONE_NV 8'h02
`define OFS_CFG_THREE_NV 8'h04
// Live map status
`define OFS_MAP_STATUS 8'h08
// Detection descriptor bytes, six dwords, low byte first
`define OFS_DESC_FIRST 8'h10
`define OFS_DESC_LAST 8'h27

// Field positions
`define BIT_UNIFORM_MAP 3
`define BIT_PARAM_TOP 2
`define BIT_SECTOR_256K 1
`define BIT_STATUS_VALID 7

// Reset values of the configuration bytes
`define RST_CFG_ONE_NV 8'h00
`define RST_CFG_THREE_NV 8'h02

// Supported index values
`define IDX_HYBRID_BOTTOM 3'h1
`define IDX_HYBRID_TOP 3'h3
`define IDX_UNIFORM 3'h5

// Map kinds
`define MAP_NONE 2'h0
`define MAP_HYBRID_BOTTOM 2'h1
`define MAP_HYBRID_TOP 2'h2
`define MAP_UNIFORM 2'h3

// Descriptor fields
`define DESC_INSTR_READ_ANY 8'h65
`define DESC_LEN_LATENCY 8'hff
`define DESC_LOW_MORE 8'hfc
`define DESC_LOW_END 8'hfd
`define DESC_MASK_FIRST 8'h08
`define DESC_MASK_SECOND 8'h04
`define DESC_MASK_THIRD 8'h02

`endif

// ---- core/sector_map_decode.v ----
/*
 Decoder from a three-bit configuration index to the sector map kind.
 Assumes the index is held stable by registers in the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sector_map_regs.vh"

module sector_map_decode
(
   input wire [2:0] i_index,
   output reg o_valid,
   output reg [1:0] o_map
);

   always @*
   begin
      o_valid = 1'b1;
      case (i_index)
         `IDX_HYBRID_BOTTOM: o_map = `MAP_HYBRID_BOTTOM;
         `IDX_HYBRID_TOP: o_map = `MAP_HYBRID_TOP;
         `IDX_UNIFORM: o_map = `MAP_UNIFORM;
         default:
         begin
            o_valid = 1'b0;
            o_map = `MAP_NONE;
         end
      endcase
   end

endmodule // sector_map_decode
`default_nettype wire

// ---- core/sector_map_detection.v ----
/*
 Sector map detection inside the flash: the two nonvolatile configuration
 bytes, the detection descriptors a host reads to find them, and the
 decoded sector map. Assumes a same-clock register master that issues
 one-cycle strobes and takes read data in the following cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sector_map_regs.vh"

module sector_map_detection
(
   input wire i_mclk,
   input wire i_rst,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   output reg [2:0] o_map_index,
   output reg o_map_valid,
   output reg [1:0] o_map_kind,
   output reg o_uniform,
   output reg o_param_top,
   output reg o_sector_256k
);

   reg [7:0] config_reg_one_nonvolatile_r;
   reg [7:0] config_reg_three_nonvolatile_r;
   reg [7:0] rdata_nxt;
   reg [7:0] desc_byte;
   wire [4:0] desc_idx;
   wire in_desc;
   wire [2:0] index_nxt;
   wire valid_nxt;
   wire [1:0] kind_nxt;
   wire uniform_map_select_bit;
   wire param_sector_top_select;
   wire large_sector_size_bit;
   reg [7:0] desc_low;
   reg [7:0] desc_mask;
   reg [7:0] desc_target;
   wire [1:0] desc_num;
   wire [2:0] desc_sel;
   wire sel_cfg_one;
   wire sel_cfg_three;
   wire sel_status;
   wire wr_cfg_one;
   wire wr_cfg_three;

   assign uniform_map_select_bit =
      config_reg_three_nonvolatile_r[`BIT_UNIFORM_MAP];
   assign param_sector_top_select =
      config_reg_one_nonvolatile_r[`BIT_PARAM_TOP];
   assign large_sector_size_bit =
      config_reg_three_nonvolatile_r[`BIT_SECTOR_256K];

   // Most significant first
   assign index_nxt = {uniform_map_select_bit, param_sector_top_select,
                       large_sector_size_bit};

   // Index to map kind
   sector_map_decode u_decode
   (
      .i_index(index_nxt),
      .o_valid(valid_nxt),
      .o_map(kind_nxt)
   );

   // Address decode shared by the write and read paths
   assign sel_cfg_one = (i_addr == `OFS_CFG_ONE_NV);
   assign sel_cfg_three = (i_addr == `OFS_CFG_THREE_NV);
   assign sel_status = (i_addr == `OFS_MAP_STATUS);
   assign wr_cfg_one = i_wr && sel_cfg_one;
   assign wr_cfg_three = i_wr && sel_cfg_three;

   // Configuration byte writes
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         config_reg_one_nonvolatile_r <= `RST_CFG_ONE_NV;
         config_reg_three_nonvolatile_r <= `RST_CFG_THREE_NV;
      end
      else
      begin
         if (wr_cfg_one)
            config_reg_one_nonvolatile_r <= i_wdata;
         if (wr_cfg_three)
            config_reg_three_nonvolatile_r <= i_wdata;
      end
   end

   // Decoded map outputs
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_map_index <= 3'h0;
         o_map_valid <= 1'b0;
         o_map_kind <= `MAP_NONE;
      end
      else
      begin
         o_map_index <= index_nxt;
         o_map_valid <= valid_nxt;
         o_map_kind <= kind_nxt;
      end
   end

   // Single configuration bit outputs
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_uniform <= 1'b0;
         o_param_top <= 1'b0;
         o_sector_256k <= 1'b0;
      end
      else
      begin
         o_uniform <= uniform_map_select_bit;
         o_param_top <= param_sector_top_select;
         o_sector_256k <= large_sector_size_bit;
      end
   end

   // Descriptor table, three dword pairs in read order
   assign in_desc = (i_addr >= `OFS_DESC_FIRST) &&
                    (i_addr <= `OFS_DESC_LAST);
   assign desc_idx = i_addr[4:0] - 5'h10;
   assign desc_num = desc_idx[4:3];
   assign desc_sel = desc_idx[2:0];

   // Fields that differ from one descriptor to the next
   always @*
   begin
      desc_low = 8'h00;
      desc_mask = 8'h00;
      desc_target = 8'h00;
      case (desc_num)
         2'h0:
         begin
            desc_low = `DESC_LOW_MORE;
            desc_mask = `DESC_MASK_FIRST;
            desc_target = `OFS_CFG_THREE_NV;
         end
         2'h1:
         begin
            desc_low = `DESC_LOW_MORE;
            desc_mask = `DESC_MASK_SECOND;
            desc_target = `OFS_CFG_ONE_NV;
         end
         2'h2:
         begin
            desc_low = `DESC_LOW_END;
            desc_mask = `DESC_MASK_THIRD;
            desc_target = `OFS_CFG_THREE_NV;
         end
         default:
         begin
            desc_low = 8'h00;
            desc_mask = 8'h00;
            desc_target = 8'h00;
         end
      endcase
   end

   // Byte within the dword pair
   always @*
   begin
      case (desc_sel)
         3'h0: desc_byte = desc_low;
         3'h1: desc_byte = `DESC_INSTR_READ_ANY;
         3'h2: desc_byte = `DESC_LEN_LATENCY;
         3'h3: desc_byte = desc_mask;
         3'h4: desc_byte = desc_target;
         3'h5, 3'h6, 3'h7: desc_byte = 8'h00;
         default: desc_byte = 8'h00;
      endcase
   end

   // Read mux, unmapped reads return zero
   always @*
   begin
      rdata_nxt = 8'h00;
      if (sel_cfg_one)
         rdata_nxt = config_reg_one_nonvolatile_r;
      else if (sel_cfg_three)
         rdata_nxt = config_reg_three_nonvolatile_r;
      else if (sel_status)
      begin
         rdata_nxt[`BIT_STATUS_VALID] = valid_nxt;
         rdata_nxt[2:0] = index_nxt;
      end
      else if (in_desc)
         rdata_nxt = desc_byte;
   end

   // Read data stands one cycle only
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= rdata_nxt;
      else
         o_rdata <= 8'h00;
   end

endmodule // sector_map_detection
`default_nettype wire

// ---- test/sector_map_chk.sv ----
/* Map output checks. Assumes binding to the detection top module. */
`timescale 1ns/100ps
`default_nettype none
module sector_map_chk
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic [2:0] o_map_index,
   input wire logic o_map_valid,
   input wire logic [1:0] o_map_kind,
   input wire logic o_uniform,
   input wire logic o_param_top,
   input wire logic o_sector_256k
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // Lone write, so the outputs two edges on reflect it
   sequence wr_three;
      i_wr && i_addr == 8'h04 ##1 !(i_wr && i_addr == 8'h04);
   endsequence
   sequence wr_one;
      i_wr && i_addr == 8'h02 ##1 !(i_wr && i_addr == 8'h02);
   endsequence
   uniform_bit_a: assert property (wr_three |=> o_uniform == $past(i_wdata[3], 2))
      else $error("uniform flag wrong");
   top_bit_a: assert property (wr_one |=> o_param_top == $past(i_wdata[2], 2))
      else $error("top flag wrong");
   size_bit_a: assert property (wr_three |=> o_sector_256k == $past(i_wdata[1], 2))
      else $error("size flag wrong");
   map_kind_a: assert property (o_map_valid == (o_map_index inside {3'h1, 3'h3, 3'h5})
      && o_map_kind == (o_map_index == 3'h1 ? 2'h1 : o_map_index == 3'h3 ? 2'h2 :
      o_map_index == 3'h5 ? 2'h3 : 2'h0))
      else $error("map kind wrong");
endmodule // sector_map_chk
bind sector_map_detection sector_map_chk i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_map_index(o_map_index),
   .o_map_valid(o_map_valid), .o_map_kind(o_map_kind), .o_uniform(o_uniform),
   .o_param_top(o_param_top), .o_sector_256k(o_sector_256k));
`default_nettype wire

// ---- test/map_host.sv ----
/* Host model: register port master and descriptor walk. Assumes same clock. */
`timescale 1ns/100ps
`default_nettype none
module map_host
(
   input wire logic i_mclk,
   input wire logic [7:0] i_rdata,
   output logic [7:0] o_addr = 8'h00,
   output logic [7:0] o_wdata = 8'h00,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_mclk);
      o_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_mclk);
      o_rd <= 1'b0;
      // Read data stand in the cycle after the strobe; take them at its end
      @(posedge i_mclk);
      d = i_rdata;
   endtask
   // Shifts in one masked bit per descriptor until the end mark
   task automatic detect(output logic [2:0] idx);
      logic [7:0] b [5];
      logic [7:0] dat;
      logic [2:0] acc;
      acc = 3'h0;
      for (int k = 0; k < 3; k++)
      begin
         for (int j = 0; j < 5; j++)
            rd(8'h10 + 8'(k * 8 + j), b[j]);
         rd(b[4], dat);
         acc = {acc[1:0], b[1] == 8'h65 && b[2] == 8'hff && |(dat & b[3])};
         if (b[0][0])
            break;
      end
      idx = acc;
   endtask
endmodule // map_host
`default_nettype wire

// ---- test/sector_map_detection_test.sv ----
/* Bench: reset values, each map and one unsupported mix. Assumes the host model. */
`timescale 1ns/100ps
`default_nettype none
module sector_map_detection_test;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   wire [7:0] a, w, r;
   wire wr, rd, v, u, t, s;
   wire [2:0] mi;
   wire [1:0] mk;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] d;
   logic [2:0] idx;
   // Config three, config one, index, kind
   logic [23:0] cases [4] = '{24'h020011, 24'h020432, 24'h0a0053, 24'h080040};
   initial forever #20 i_mclk = ~i_mclk;
   map_host i_map_host (.i_mclk(i_mclk), .i_rdata(r), .o_addr(a), .o_wdata(w),
      .o_wr(wr), .o_rd(rd));
   sector_map_detection i_sector_map_detection (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_addr(a), .i_wdata(w), .i_wr(wr), .i_rd(rd), .o_rdata(r), .o_map_index(mi),
      .o_map_valid(v), .o_map_kind(mk), .o_uniform(u), .o_param_top(t), .o_sector_256k(s));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge i_mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (6) @(posedge i_mclk);
      i_rst <= 1'b0;
      i_map_host.rd(8'h02, d);
      chk(d, 8'h00);
      i_map_host.rd(8'h04, d);
      chk(d, 8'h02);
      i_map_host.rd(8'h08, d);
      chk(d, 8'h81);
      i_map_host.rd(8'h30, d);
      chk(d, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         i_map_host.wr(8'h04, cases[i][23:16]);
         i_map_host.wr(8'h02, cases[i][15:8]);
         if (|cases[i][3:0])
            i_map_host.detect(idx);
         else
         begin
            i_map_host.rd(8'h08, d);
            chk(d, cases[i][7:0] >> 4);
            idx = d[2:0];
         end
         chk({5'h0, idx}, cases[i][7:0] >> 4);
         chk({5'h0, mi}, cases[i][7:0] >> 4);
         chk({5'h0, u, t, s}, cases[i][7:0] >> 4);
         chk({6'h0, mk}, {4'h0, cases[i][3:0]});
         chk({7'h0, v}, {7'h0, |cases[i][3:0]});
         $display("test map %0d done", i);
      end
      give_verdict();
   end
endmodule // sector_map_detection_test
`default_nettype wire
